/* common/nvc_pkg.sv */
// package for the host-side controller of a shadowed static ram
// assumes a 25 MHz core clock and an asynchronous byte-wide memory part
package nvc_pkg;
   localparam int CLK_MHZ = 25;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   // phase lengths in core cycles (40 ns each)
   localparam int SETUP_CYC = 1;
   localparam int STROBE_CYC = 2;
   localparam int HOLD_CYC = 1;
   // store_duration 10 ms, longest; recall_duration allowance 550 us
   localparam int STORE_DURATION_US = 10000;
   localparam int STORE_CYC = STORE_DURATION_US * CLK_MHZ;
   localparam int RECALL_DURATION_US = 550;
   localparam int RECALL_CYC = RECALL_DURATION_US * CLK_MHZ;
   // access_completion_allowance 1 us, least
   localparam int ALLOW_US = 1;
   localparam int ALLOW_CYC = ALLOW_US * CLK_MHZ;
   // software sequence addresses
   localparam logic [14:0] SEQ_A0 = 15'h0E38;
   localparam logic [14:0] SEQ_A1 = 15'h31C7;
   localparam logic [14:0] SEQ_A2 = 15'h03E0;
   localparam logic [14:0] SEQ_A3 = 15'h3C1F;
   localparam logic [14:0] SEQ_A4 = 15'h303F;
   localparam logic [14:0] SEQ_STORE = 15'h0FC0;
   localparam logic [14:0] SEQ_RECALL = 15'h0C63;

   typedef enum logic [1:0] {
      NVC_CMD_READ = 2'b00,
      NVC_CMD_WRITE = 2'b01,
      NVC_CMD_STORE = 2'b10,
      NVC_CMD_RECALL = 2'b11
   } nvc_cmd_type;

   typedef struct packed {
      nvc_cmd_type cmd;
      logic [14:0] addr;
      logic [7:0] wdata;
   } nvc_req_type;

   typedef struct packed {
      logic chip_on_n;
      logic output_drive_n;
      logic input_latch_n;
   } nvc_strobe_type;
endpackage

/* core/nvc_ctrl.sv */
// host controller issuing reads, writes, software store and recall
// assumes the memory pins are wired straight to the part, one core clock
// Operation
// - host holds address through write end
// - six reads ending 0FC0 start store
// - six reads ending 0C63 start recall
// - sequence uses chip-framed reads only
`timescale 1ns/1ns
module nvc_ctrl #(
   parameter int STORE_CYC = nvc_pkg::STORE_CYC,
   parameter int RECALL_CYC = nvc_pkg::RECALL_CYC
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire nvc_pkg::nvc_req_type req_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   input wire logic hw_save_i,
   output logic written_o,
   output logic [14:0] byte_location_lines_o,
   output nvc_pkg::nvc_strobe_type strobe_o,
   input wire logic [7:0] shared_byte_lines_i,
   output logic [7:0] shared_byte_lines_o,
   output logic shared_byte_lines_oe_o,
   input wire logic hard_save_busy_n_i,
   output logic hard_save_busy_n_o,
   output logic hard_save_busy_n_oe_o
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_SETUP = 4'b0001,
      ST_STROBE = 4'b0010,
      ST_HOLD = 4'b0011,
      ST_SEQ = 4'b0100,
      ST_NV_WAIT = 4'b0101,
      ST_HW_LOW = 4'b0110,
      ST_HW_BUSY = 4'b0111,
      ST_HW_REL = 4'b1000
   } nvc_state_type;

   localparam int CW = $clog2(STORE_CYC + RECALL_CYC + 1);

   nvc_state_type state_q;
   logic [CW-1:0] cnt_q;
   logic [2:0] seq_idx_q;
   nvc_pkg::nvc_req_type cur_q;
   logic [7:0] dq_in_meta_q, dq_in_q;
   logic hsb_meta_q, hsb_q;
   logic written_q;
   logic [14:0] seq_addr;
   logic [2:0] seq_nxt;

   // pin inputs through two flops
   always_ff @(posedge core_clk_i) begin
      dq_in_meta_q <= shared_byte_lines_i;
      dq_in_q <= dq_in_meta_q;
      hsb_meta_q <= hard_save_busy_n_i;
      hsb_q <= hsb_meta_q;
   end

   // address of the next sequence step; step 0 is loaded in idle
   assign seq_nxt = seq_idx_q + 3'd1;

   always_comb begin
      case (seq_nxt)
         3'd1: seq_addr = nvc_pkg::SEQ_A1;
         3'd2: seq_addr = nvc_pkg::SEQ_A2;
         3'd3: seq_addr = nvc_pkg::SEQ_A3;
         3'd4: seq_addr = nvc_pkg::SEQ_A4;
         default: begin
            if (cur_q.cmd == nvc_pkg::NVC_CMD_STORE) begin
               seq_addr = nvc_pkg::SEQ_STORE;
            end else begin
               seq_addr = nvc_pkg::SEQ_RECALL;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         seq_idx_q <= 3'd0;
         cur_q <= '0;
         req_ready_o <= 1'b0;
         rdata_o <= 8'h00;
         rdata_valid_o <= 1'b0;
         written_o <= 1'b0;
         written_q <= 1'b0;
         byte_location_lines_o <= 15'h0000;
         strobe_o <= 3'b111;
         shared_byte_lines_o <= 8'h00;
         shared_byte_lines_oe_o <= 1'b0;
         hard_save_busy_n_o <= 1'b0;
         hard_save_busy_n_oe_o <= 1'b0;
      end else begin
         rdata_valid_o <= 1'b0;
         req_ready_o <= 1'b0;
         written_o <= written_q;
         case (state_q)
            ST_IDLE: begin
               // wait for device busy to clear first
               if (hsb_q && hw_save_i) begin
                  hard_save_busy_n_o <= 1'b0;
                  hard_save_busy_n_oe_o <= 1'b1;
                  cnt_q <= CW'(nvc_pkg::ALLOW_CYC);
                  state_q <= ST_HW_LOW;
               end else if (hsb_q && req_valid_i) begin
                  cur_q <= req_i;
                  req_ready_o <= 1'b1;
                  seq_idx_q <= 3'd0;
                  state_q <= ST_SETUP;
                  if (req_i.cmd == nvc_pkg::NVC_CMD_STORE ||
                      req_i.cmd == nvc_pkg::NVC_CMD_RECALL) begin
                     byte_location_lines_o <= nvc_pkg::SEQ_A0;
                  end else begin
                     byte_location_lines_o <= req_i.addr;
                  end
                  shared_byte_lines_o <= req_i.wdata;
               end
            end
            ST_SETUP: begin
               // address settles before any strobe
               cnt_q <= CW'(nvc_pkg::STROBE_CYC);
               state_q <= ST_STROBE;
               if (cur_q.cmd == nvc_pkg::NVC_CMD_WRITE) begin
                  // output drive stays high for writes
                  strobe_o <= 3'b010;
                  shared_byte_lines_oe_o <= 1'b1;
               end else if (cur_q.cmd == nvc_pkg::NVC_CMD_READ) begin
                  strobe_o <= 3'b001;
               end else begin
                  // sequence reads framed by chip_on_n only
                  strobe_o <= 3'b011;
               end
            end
            ST_STROBE: begin
               if (cnt_q > CW'(1)) begin
                  cnt_q <= cnt_q - CW'(1);
               end else begin
                  if (cur_q.cmd == nvc_pkg::NVC_CMD_WRITE) begin
                     written_q <= 1'b1;
                  end
                  strobe_o <= 3'b111;
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               // address and data held one cycle past strobe rise
               shared_byte_lines_oe_o <= 1'b0;
               // pin flops add two cycles, so the byte is taken here
               if (cur_q.cmd == nvc_pkg::NVC_CMD_READ) begin
                  rdata_o <= dq_in_q;
                  rdata_valid_o <= 1'b1;
               end
               if (cur_q.cmd == nvc_pkg::NVC_CMD_READ ||
                   cur_q.cmd == nvc_pkg::NVC_CMD_WRITE) begin
                  state_q <= ST_IDLE;
               end else begin
                  state_q <= ST_SEQ;
               end
            end
            ST_SEQ: begin
               // nothing else may interleave, or the device aborts
               if (seq_idx_q == 3'd5) begin
                  if (cur_q.cmd == nvc_pkg::NVC_CMD_STORE) begin
                     cnt_q <= CW'(STORE_CYC);
                  end else begin
                     cnt_q <= CW'(RECALL_CYC);
                  end
                  state_q <= ST_NV_WAIT;
               end else begin
                  seq_idx_q <= seq_nxt;
                  byte_location_lines_o <= seq_addr;
                  state_q <= ST_SETUP;
               end
            end
            ST_NV_WAIT: begin
               // device disabled; wait worst case
               if (cnt_q > CW'(1)) begin
                  cnt_q <= cnt_q - CW'(1);
               end else begin
                  written_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            ST_HW_LOW: begin
               // hold low for exactly the completion allowance, 25 cycles
               if (cnt_q > CW'(1)) begin
                  cnt_q <= cnt_q - CW'(1);
               end else begin
                  hard_save_busy_n_oe_o <= 1'b0;
                  cnt_q <= CW'(STORE_CYC);
                  state_q <= ST_HW_BUSY;
               end
            end
            ST_HW_BUSY: begin
               // device keeps pin low until store done
               if (hsb_q) begin
                  state_q <= ST_HW_REL;
               end else if (cnt_q > CW'(1)) begin
                  cnt_q <= cnt_q - CW'(1);
               end else begin
                  state_q <= ST_HW_REL;
               end
            end
            ST_HW_REL: begin
               written_q <= 1'b0;
               if (!hw_save_i) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

/* tb/nvc_ctrl_properties.sv */
// pin-level assertions on the host controller
// assumes binding into nvc_ctrl, one clock
`timescale 1ns/1ns
module nvc_ctrl_chk (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic req_ready_o,
   input wire logic rdata_valid_o,
   input wire logic written_o,
   input wire logic [14:0] byte_location_lines_o,
   input wire nvc_pkg::nvc_strobe_type strobe_o,
   input wire logic [7:0] shared_byte_lines_o,
   input wire logic shared_byte_lines_oe_o,
   input wire logic hard_save_busy_n_i
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_rd_end;
      $rose(strobe_o.chip_on_n) ##0 !$past(strobe_o.output_drive_n);
   endsequence
   sequence s_wr_on;
      !strobe_o.input_latch_n ##1 !strobe_o.input_latch_n;
   endsequence
   property p_wo;
      !strobe_o.input_latch_n |-> strobe_o.output_drive_n;
   endproperty
   a_wo: assert property (p_wo) else $error("drive low in write");
   property p_rf;
      !strobe_o.output_drive_n |-> !strobe_o.chip_on_n;
   endproperty
   a_rf: assert property (p_rf) else $error("drive without chip");
   property p_ah;
      !strobe_o.chip_on_n ##1 !strobe_o.chip_on_n
         |-> $stable(byte_location_lines_o);
   endproperty
   a_ah: assert property (p_ah) else $error("address moved");
   property p_wd;
      s_wr_on |-> shared_byte_lines_oe_o && $stable(shared_byte_lines_o);
   endproperty
   a_wd: assert property (p_wd) else $error("write data moved");
   property p_we;
      $fell(strobe_o.input_latch_n) |-> shared_byte_lines_oe_o [*3];
   endproperty
   a_we: assert property (p_we) else $error("write not driven");
   property p_sb;
      !hard_save_busy_n_i [*6] |-> strobe_o.input_latch_n;
   endproperty
   a_sb: assert property (p_sb) else $error("write while busy");
   property p_rv;
      s_rd_end |=> rdata_valid_o;
   endproperty
   a_rv: assert property (p_rv) else $error("data off frame");
   property p_wf;
      $fell(strobe_o.input_latch_n) |-> ##[0:4] written_o;
   endproperty
   a_wf: assert property (p_wf) else $error("flag not set");
endmodule
bind nvc_ctrl nvc_ctrl_chk u_chk (.core_clk_i(core_clk_i),
   .srst_i(srst_i), .req_ready_o(req_ready_o),
   .rdata_valid_o(rdata_valid_o), .written_o(written_o),
   .byte_location_lines_o(byte_location_lines_o), .strobe_o(strobe_o),
   .shared_byte_lines_o(shared_byte_lines_o),
   .shared_byte_lines_oe_o(shared_byte_lines_oe_o),
   .hard_save_busy_n_i(hard_save_busy_n_i));

/* tb/nvc_mem_model.sv */
// behavioural shadowed byte ram
// assumes the bench resolves the shared pins
`timescale 1ns/1ns
module nvc_mem_model (
   input wire logic [14:0] addr_i,
   input wire nvc_pkg::nvc_strobe_type st_i,
   input wire logic [7:0] d_i,
   input wire logic busy_n_i,
   output logic [7:0] d_o,
   output logic pull_o
);
   logic [7:0] mem [32768];
   logic [7:0] nv [32768];
   logic [74:0] tab;
   logic [14:0] ra, wa;
   logic [7:0] wd;
   logic ra_on = 1'b0, wa_on = 1'b0, wr = 1'b0, bsy = 1'b0;
   logic ok;
   int seq = 0;
   event ev_st, ev_rc;
   assign tab = {nvc_pkg::SEQ_A0, nvc_pkg::SEQ_A1, nvc_pkg::SEQ_A2,
      nvc_pkg::SEQ_A3, nvc_pkg::SEQ_A4};
   assign ok = busy_n_i && !bsy;
   initial pull_o = 1'b0;
   initial for (int i = 0; i < 32768; i++) begin
      nv[i] = 8'h00;
      mem[i] = 8'h00;
   end
   // released lines show the inverse, never a stale byte
   assign d_o = (!st_i.chip_on_n && !st_i.output_drive_n &&
      st_i.input_latch_n && ok) ? mem[addr_i] : ~mem[addr_i];
   always @(st_i or addr_i or d_i) begin
      if (!st_i.chip_on_n && !st_i.input_latch_n && ok) begin
         wa_on = 1'b1;
         wa = addr_i;
         wd = d_i;
      end else if (wa_on) begin
         wa_on = 1'b0;
         mem[wa] = wd;
         wr = 1'b1;
         seq = 0;
      end
      if (!st_i.chip_on_n && st_i.input_latch_n && ok) begin
         ra_on = 1'b1;
         ra = addr_i;
      end else if (ra_on && st_i.chip_on_n) begin
         ra_on = 1'b0;
         if (seq == 5) begin
            if (ra == nvc_pkg::SEQ_STORE) ->ev_st;
            if (ra == nvc_pkg::SEQ_RECALL) ->ev_rc;
            seq = 0;
         end else seq = (ra == tab[15*(4-seq) +: 15]) ? seq + 1 :
            int'(ra == nvc_pkg::SEQ_A0);
      end
   end
   always @(ev_st) begin
      pull_o = 1'b1;
      bsy = 1'b1;
      nv = mem;
      #1200 pull_o = 1'b0;
      bsy = 1'b0;
      wr = 1'b0;
   end
   always @(ev_rc) begin
      bsy = 1'b1;
      mem = nv;
      #1200 bsy = 1'b0;
      wr = 1'b0;
   end
   // power-fall store shares the busy-pin path here
   always @(negedge busy_n_i) if (!pull_o && wr) ->ev_st;
endmodule

/* tb/tb_nvc_ctrl.sv */
// bench for the host controller against the ram model
// assumes store and recall waits shortened to 50 cycles
`timescale 1ns/1ns
module tb_nvc_ctrl;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   nvc_pkg::nvc_req_type req = '0;
   logic vld = 1'b0;
   logic hw = 1'b0;
   logic rdy, rv, wrt, h_oe, b_o, b_oe, pull;
   logic [7:0] rd, h_d, m_d, got;
   logic [14:0] adr;
   nvc_pkg::nvc_strobe_type st;
   wire logic [7:0] dq = h_oe ? h_d : m_d;
   wire logic bn = !(b_oe && !b_o) && !pull;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int low = 0;
   always #20 core_clk_i = ~core_clk_i;
   nvc_ctrl #(.STORE_CYC(50), .RECALL_CYC(50)) DUT (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .req_i(req), .req_valid_i(vld), .req_ready_o(rdy),
      .rdata_o(rd), .rdata_valid_o(rv), .hw_save_i(hw), .written_o(wrt),
      .byte_location_lines_o(adr), .strobe_o(st), .shared_byte_lines_i(dq),
      .shared_byte_lines_o(h_d), .shared_byte_lines_oe_o(h_oe),
      .hard_save_busy_n_i(bn), .hard_save_busy_n_o(b_o),
      .hard_save_busy_n_oe_o(b_oe));
   nvc_mem_model u_mem (.addr_i(adr), .st_i(st), .d_i(dq), .busy_n_i(bn),
      .d_o(m_d), .pull_o(pull));
   task automatic results();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t %h %h", $time, g, e);
      end
   endtask
   task automatic op(input nvc_pkg::nvc_cmd_type c, input logic [14:0] a,
         input logic [7:0] d);
      int i;
      @(negedge core_clk_i);
      req = '{c, a, d};
      vld = 1'b1;
      for (i = 0; i < 600 && rdy !== 1'b1; i++) @(negedge core_clk_i);
      vld = 1'b0;
      for (i = 0; i < 9 && c == nvc_pkg::NVC_CMD_READ && rv !== 1'b1; i++)
         @(negedge core_clk_i);
      got = rd;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      op(nvc_pkg::NVC_CMD_WRITE, a, d);
   endtask
   task automatic rdx(input logic [14:0] a, input logic [7:0] e);
      op(nvc_pkg::NVC_CMD_READ, a, 8'h00);
      chk(got, e);
   endtask
   // own pull is 25 cycles; model store holds 30, margin for the race
   task automatic hwp(input logic e);
      int l0;
      @(negedge core_clk_i);
      l0 = low;
      hw = 1'b1;
      repeat (120) @(negedge core_clk_i);
      hw = 1'b0;
      chk({7'h00, (low - l0) >= 28}, {7'h00, e});
   endtask
   task automatic t_rw();
      wr(15'h7FFF, 8'hA5);
      wr(15'h0000, 8'h5A);
      rdx(15'h7FFF, 8'hA5);
      rdx(15'h0000, 8'h5A);
      chk({7'h00, wrt}, 8'h01);
   endtask
   task automatic t_sw();
      wr(15'h0001, 8'h11);
      op(nvc_pkg::NVC_CMD_STORE, 15'h0000, 8'h00);
      rdx(15'h0001, 8'h11);
      chk({7'h00, wrt}, 8'h00);
      wr(15'h0001, 8'h22);
      op(nvc_pkg::NVC_CMD_RECALL, 15'h0000, 8'h00);
      rdx(15'h0001, 8'h11);
   endtask
   task automatic t_ab();
      logic [14:0] s [7] = '{nvc_pkg::SEQ_A0, nvc_pkg::SEQ_A1,
         nvc_pkg::SEQ_A2, nvc_pkg::SEQ_A3, 15'h0005, nvc_pkg::SEQ_A4,
         nvc_pkg::SEQ_STORE};
      wr(15'h0003, 8'h77);
      for (int i = 0; i < 7; i++) op(nvc_pkg::NVC_CMD_READ, s[i], 8'h00);
      op(nvc_pkg::NVC_CMD_RECALL, 15'h0000, 8'h00);
      rdx(15'h0003, 8'h00);
   endtask
   task automatic t_hw();
      wr(15'h0002, 8'h33);
      hwp(1'b1);
      wr(15'h0002, 8'h44);
      op(nvc_pkg::NVC_CMD_RECALL, 15'h0000, 8'h00);
      rdx(15'h0002, 8'h33);
      hwp(1'b0);
   endtask
   initial begin
      repeat (20) @(negedge core_clk_i);
      srst_i = 1'b0;
      t_rw();
      t_sw();
      t_ab();
      t_hw();
      results();
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (!bn) low <= low + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
endmodule
